// >>> stdd_defines.vh
// constants for the split transfer descriptor decoder
// assumes a 20 MHz core clock and an apb register master
// Overview of operation
// - endpoint bit 0 comes from descriptor bit 31, joined with bits 3:1.
// - bits 28:18 cap the bytes moved in one start-split.
// - bits 17:3 give the descriptor byte count and payload depth.
// - device clears valid bit 0 when done or on fatal error.
// - interrupt descriptor holds 11-bit max packet and 15-bit byte count.
`ifndef STDD_DEFINES_VH
`define STDD_DEFINES_VH
`define STDD_ADDR_CTRL 12'h000
`define STDD_ADDR_DW0 12'h004
`define STDD_ADDR_DW1 12'h008
`define STDD_ADDR_STATUS 12'h00C
`define STDD_ADDR_INT_STAT 12'h010
`define STDD_ADDR_INT_MASK 12'h014
`define STDD_ADDR_SPLIT 12'h018
`define STDD_EP0_BIT 31
`define STDD_MPS_HI 28
`define STDD_MPS_LO 18
`define STDD_CNT_HI 17
`define STDD_CNT_LO 3
`define STDD_VALID_BIT 0
`define STDD_EP_HI_HI 2
`define STDD_EP_HI_LO 0
`define STDD_ISO_MAX_CNT 15'h03FF
`define STDD_CTRL_RESET 32'h00000000
`define STDD_MASK_RESET 3'h0
`define STDD_SPLIT_NS 1000
`define STDD_CLK_MHZ 20
`endif

// >>> stdd_split_engine.v
// start-split sequencer: moves a byte count in chunks of at most the limit
// assumes start is a one-cycle pulse on mclk and limit is nonzero
module stdd_split_engine #(
	parameter CW = 15,
	parameter MW = 11,
	parameter SPLIT_CYCLES = 20
) (
	// clock and reset
	input wire mclk,
	input wire resetn,
	// command
	input wire start,
	input wire abort,
	input wire [CW-1:0] total,
	input wire [MW-1:0] limit,
	// progress
	output reg busy,
	output reg split_pulse,
	output reg [MW-1:0] split_bytes,
	output reg done
);
	reg [CW-1:0] remain;
	reg [15:0] timer;
	wire [CW-1:0] lim_w = {{(CW-MW){1'b0}}, limit};
	wire [CW-1:0] chunk = (remain > lim_w) ? lim_w : remain;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			split_pulse <= 1'b0;
			split_bytes <= {MW{1'b0}};
			done <= 1'b0;
			remain <= {CW{1'b0}};
			timer <= 16'h0000;
		end else begin
			split_pulse <= 1'b0;
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
			end else if (start && !busy) begin
				busy <= 1'b1;
				remain <= total;
				timer <= 16'h0000;
			end else if (busy) begin
				if (timer != 16'h0000) begin
					timer <= timer - 16'h0001;
				end else if (remain == {CW{1'b0}}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					// each start-split carries no more than the limit
					split_pulse <= 1'b1;
					split_bytes <= chunk[MW-1:0];
					remain <= remain - chunk;
					timer <= SPLIT_CYCLES[15:0];
				end
			end
		end
	end
endmodule

// >>> stdd_top.v
// descriptor decode and split execution with an apb register window
// assumes one apb master on mclk; fatal_err pin comes from another domain
`include "stdd_defines.vh"
module stdd_top #(
	parameter CW = 15,
	parameter MW = 11
) (
	// clock and reset
	input wire mclk,
	input wire resetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// downstream link events
	input wire fatal_err,
	output reg split_start,
	output reg [MW-1:0] split_size,
	output reg [3:0] split_endpoint,
	// interrupt
	output reg irq
);
	localparam [15:0] SPLIT_CYCLES = (`STDD_SPLIT_NS * `STDD_CLK_MHZ + 999) / 1000;
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_RUN = 2'd1;
	localparam [1:0] ST_CLR = 2'd2;

	// register file and status
	reg [31:0] ctrl;
	reg [31:0] dw0;
	reg [31:0] dw1;
	reg [2:0] int_stat;
	reg [2:0] int_mask;
	reg [CW-1:0] last_count;
	reg [31:0] rd;
	// sequencer
	reg [1:0] state;
	reg [1:0] next_state;
	reg launch;
	reg next_launch;
	reg clr_valid;
	// fatal pin synchroniser and edge finder
	reg err_s1;
	reg err_s2;
	reg err_s3;

	// apb handshake terms
	wire acc = psel && penable;
	wire first_acc = acc && !pready;
	wire wr = acc && pwrite;
	wire wr_land = wr && pready;
	// register selects, one per offset
	wire sel_ctrl = (paddr == `STDD_ADDR_CTRL);
	wire sel_dw0 = (paddr == `STDD_ADDR_DW0);
	wire sel_dw1 = (paddr == `STDD_ADDR_DW1);
	wire sel_status = (paddr == `STDD_ADDR_STATUS);
	wire sel_int_stat = (paddr == `STDD_ADDR_INT_STAT);
	wire sel_int_mask = (paddr == `STDD_ADDR_INT_MASK);
	wire sel_split = (paddr == `STDD_ADDR_SPLIT);
	wire mapped = sel_ctrl || sel_dw0 || sel_dw1 || sel_status ||
		sel_int_stat || sel_int_mask || sel_split;

	// engine results
	wire eng_pulse;
	wire eng_done;
	wire [MW-1:0] eng_bytes;
	// only the synchronised copy is used, so a glitch on the pin cannot split the decode
	wire fatal = err_s2 && !err_s3;

	// interrupt descriptor shares the iso layout for size and count
	wire [MW-1:0] mps = dw0[`STDD_MPS_HI:`STDD_MPS_LO];
	wire [CW-1:0] cnt = dw0[`STDD_CNT_HI:`STDD_CNT_LO];
	wire valid = dw0[`STDD_VALID_BIT];
	wire [3:0] ep = {dw1[`STDD_EP_HI_HI:`STDD_EP_HI_LO], dw0[`STDD_EP0_BIT]};
	wire over = ctrl[1] && (cnt > `STDD_ISO_MAX_CNT);

	// events and write-one clear; a set in the same cycle wins
	wire [2:0] events = {eng_done, over && launch, fatal};
	wire [2:0] w1c = (wr_land && sel_int_stat) ? pwdata[2:0] : 3'b000;
	wire [2:0] next_int_stat = (int_stat & ~w1c) | events;

	always @* begin
		case (paddr)
		`STDD_ADDR_CTRL: rd = ctrl;
		`STDD_ADDR_DW0: rd = dw0;
		`STDD_ADDR_DW1: rd = dw1;
		`STDD_ADDR_STATUS: rd = {13'h0000, last_count, 2'b00, state};
		`STDD_ADDR_INT_STAT: rd = {29'h00000000, int_stat};
		`STDD_ADDR_INT_MASK: rd = {29'h00000000, int_mask};
		`STDD_ADDR_SPLIT: rd = {17'h00000, split_endpoint, split_size};
		default: rd = 32'h00000000;
		endcase
	end

	always @* begin
		next_state = state;
		next_launch = 1'b0;
		clr_valid = 1'b0;
		case (state)
		ST_IDLE: begin
			// ctrl bit 0 polls the descriptor; invalid ones start nothing
			if (ctrl[0] && valid && !wr_land) begin
				next_launch = 1'b1;
				next_state = ST_RUN;
			end
		end
		ST_RUN: begin
			if (fatal || over || eng_done)
				next_state = ST_CLR;
		end
		ST_CLR: begin
			// hardware clear of valid after completion or fatal error
			clr_valid = 1'b1;
			next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	stdd_split_engine #(
		.CW(CW),
		.MW(MW),
		.SPLIT_CYCLES(SPLIT_CYCLES)
	) u_eng (
		.mclk(mclk),
		.resetn(resetn),
		.start(launch),
		.abort(fatal || over),
		.total(cnt),
		.limit(mps),
		.busy(),
		.split_pulse(eng_pulse),
		.split_bytes(eng_bytes),
		.done(eng_done)
	);

	// two flops before any logic reads the pin; the third only finds the edge
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			err_s1 <= 1'b0;
			err_s2 <= 1'b0;
			err_s3 <= 1'b0;
		end else begin
			err_s1 <= fatal_err;
			err_s2 <= err_s1;
			err_s3 <= err_s2;
		end
	end

	// one wait state: ready rises after the first access edge and stands one cycle
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= first_acc;
			pslverr <= first_acc && !mapped;
			if (first_acc)
				prdata <= rd;
		end
	end

	// writes land when pready is seen high
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= `STDD_CTRL_RESET;
			dw0 <= 32'h00000000;
			dw1 <= 32'h00000000;
			int_mask <= `STDD_MASK_RESET;
		end else begin
			if (wr_land) begin
				case (paddr)
				`STDD_ADDR_CTRL: ctrl <= pwdata;
				`STDD_ADDR_DW0: dw0 <= pwdata;
				`STDD_ADDR_DW1: dw1 <= pwdata;
				`STDD_ADDR_INT_MASK: int_mask <= pwdata[2:0];
				default: ;
				endcase
			end
			// the hardware clear comes last, so a stray software write cannot revive it
			if (clr_valid)
				dw0[`STDD_VALID_BIT] <= 1'b0;
		end
	end

	// irq follows the status as it will be, so it never lags the flag by a cycle
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			int_stat <= 3'b000;
			irq <= 1'b0;
		end else begin
			int_stat <= next_int_stat;
			irq <= |(next_int_stat & int_mask);
		end
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			launch <= 1'b0;
			last_count <= {CW{1'b0}};
		end else begin
			state <= next_state;
			launch <= next_launch;
			if (next_launch)
				last_count <= cnt;
		end
	end

	// split start repeats the engine pulse; size and endpoint are captured on it and hold until the next one
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			split_start <= 1'b0;
			split_size <= {MW{1'b0}};
			split_endpoint <= 4'h0;
		end else begin
			split_start <= eng_pulse;
			if (eng_pulse) begin
				split_size <= eng_bytes;
				split_endpoint <= ep;
			end
		end
	end
endmodule

// >>> stdd_top_sva.sv
// port assertions for stdd_top
// assumes one mclk domain, bound into every stdd_top
module stdd_top_sva #(
	parameter CW = 15,
	parameter MW = 11
) (
	input wire mclk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire split_start,
	input wire [MW-1:0] split_size,
	input wire [3:0] split_endpoint
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_gap; split_start |=> !split_start [*8]; endproperty
	a_gap: assert property (p_gap) else $error("splits too close");
	property p_size; split_start |-> split_size != 0; endproperty
	a_size: assert property (p_size) else $error("empty split");
	property p_ep; split_start |=> $stable(split_endpoint); endproperty
	a_ep: assert property (p_ep) else $error("endpoint moved");
	property p_hold; split_start |=> $stable(split_size); endproperty
	a_hold: assert property (p_hold) else $error("size moved");
	property p_rdy; pready |-> psel && penable ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("stray ready");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("lone error");
endmodule
bind stdd_top stdd_top_sva #(.CW(CW), .MW(MW)) u_sva (.mclk(mclk), .resetn(resetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.split_start(split_start), .split_size(split_size), .split_endpoint(split_endpoint));

// >>> stdd_link_model.sv
// downstream link stand-in: raises a fatal fault on request
// assumes trip comes from the mclk domain
module stdd_link_model (
	input wire mclk,
	input wire trip,
	output logic fatal_err
);
	timeunit 1ns;
	timeprecision 1ns;
	initial fatal_err = 1'b0;
	always @(posedge mclk) fatal_err <= trip;
endmodule

// >>> tb_split_transfer_descriptor_decode.sv
// self-checking bench for stdd_top with a link stand-in
// assumes 20 MHz mclk, apb the only register path
`include "stdd_defines.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_split_transfer_descriptor_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, trip = 0, err;
	logic fatal_err, pready, pslverr, split_start, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, q, prdata, seed = 32'h5CDCE77C;
	logic [10:0] split_size;
	logic [3:0] split_endpoint;
	int failures = 0, num_checks = 0, nsplit = 0, n0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) if (split_start) nsplit <= nsplit + 1;
	stdd_top dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fatal_err(fatal_err), .split_start(split_start),
		.split_size(split_size), .split_endpoint(split_endpoint), .irq(irq));
	stdd_link_model link (.mclk(mclk), .trip(trip), .fatal_err(fatal_err));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// sizes are worked out here, one start-split at a time
	task automatic xfer(input int c, input int l, input logic [3:0] ep);
		int rem, n;
		rem = c;
		n0 = nsplit;
		apb(`STDD_ADDR_DW1, 1, {29'h0, ep[3:1]});
		apb(`STDD_ADDR_DW0, 1, {ep[0], 2'b00, l[10:0], c[14:0], 3'b001});
		while (rem > 0) begin
			n = 0;
			while (split_start !== 1'b1 && n < 200) begin
				@(posedge mclk);
				n++;
			end
			`CHK("split seen", 1'b1, split_start)
			`CHK("size", 11'((rem < l) ? rem : l), split_size)
			`CHK("endpoint", ep, split_endpoint)
			rem -= l;
			@(posedge mclk);
		end
		repeat (4) @(posedge mclk);
		`CHK("count", (c + l - 1) / l, nsplit - n0)
		// the valid clear follows the last split by a full spacing; poll, bounded
		n = 0;
		do begin
			apb(`STDD_ADDR_DW0, 0, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 60);
		`CHK("valid", 1'b0, q[0])
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#4000000;
		failures++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1;
		apb(12'h01C, 0, 0);
		`CHK("unmapped", 1'b1, err)
		apb(`STDD_ADDR_INT_MASK, 1, 32'h7);
		apb(`STDD_ADDR_CTRL, 1, 32'h3);
		xfer(300, 188, 4'hB);
		`CHK("irq", 1'b1, irq)
		apb(`STDD_ADDR_INT_STAT, 1, 32'h7);
		@(posedge mclk);
		`CHK("irq clr", 1'b0, irq)
		xfer(1023, 192, 4'h4);
		repeat (3) xfer(rnd() % 400 + 1, rnd() % 200 + 1, 4'(rnd()));
		n0 = nsplit;
		apb(`STDD_ADDR_DW0, 1, {3'b0, 11'd8, 15'd8, 3'b000});
		repeat (30) @(posedge mclk);
		`CHK("skip idle", n0, nsplit)
		apb(`STDD_ADDR_DW0, 1, {3'b0, 11'd8, 15'd1024, 3'b001});
		repeat (60) @(posedge mclk);
		`CHK("skip", n0, nsplit)
		apb(`STDD_ADDR_INT_STAT, 0, 0);
		`CHK("over", 1'b1, q[1])
		// abort mid-run: fault arrives after the first split
		apb(`STDD_ADDR_DW0, 1, {3'b0, 11'd8, 15'd1000, 3'b001});
		wait (split_start === 1'b1);
		trip <= 1;
		repeat (10) @(posedge mclk);
		apb(`STDD_ADDR_DW0, 0, 0);
		`CHK("fatal", 1'b0, q[0])
		apb(`STDD_ADDR_INT_STAT, 0, 0);
		`CHK("fatal flag", 1'b1, q[0])
		trip <= 0;
		complete_run();
	end
endmodule
